// ### rtl/codec_port_pkg.sv
// Purpose: Shared constants and types of the codec serial port and clocking block
// Assumes: One system clock that stands in for the pin master clock
// Notes:   Control register indices, field positions, reset values and counts
package codec_port_pkg;
	// ---------------------------------------------------------------------
	// Widths and counts
	// ---------------------------------------------------------------------
	localparam int          WORD_W         = 16;
	localparam int          CR_COUNT       = 6;
	localparam int          CR_W           = 8;
	localparam int          MAX_CASCADE    = 8;
	localparam logic [2:0]  RESET_INNER_MASTER_CLOCK    = 3'h4;
	localparam logic [6:0]  MIN_BIT_SYS    = 7'h08;
	localparam int          LEAD_STEP_LOG2 = 3;
	localparam logic [7:0]  CR_RESET       = 8'h00;
	// ---------------------------------------------------------------------
	// Control register indices
	// ---------------------------------------------------------------------
	localparam logic [2:0]  CR_A = 3'h0;
	localparam logic [2:0]  CR_B = 3'h1;
	localparam logic [2:0]  CR_C = 3'h2;
	localparam logic [2:0]  CR_D = 3'h3;
	localparam logic [2:0]  CR_E = 3'h4;
	// ---------------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------------
	localparam int A_MODE_BIT   = 0;
	localparam int A_MIXED_BIT  = 1;
	localparam int A_SWRST_BIT  = 7;
	localparam int B_SAMPLE_LO  = 0;
	localparam int B_BITCLK_LO  = 2;
	localparam int B_MASTER_LO  = 4;
	localparam int C_BUFFERED_REFERENCE_PIN_BIT = 6;
	localparam int D_MUTE_BIT   = 7;
	localparam int E_LEAD_LO    = 0;
	localparam int W_CTRL_BIT   = 15;
	localparam int W_READ_BIT   = 14;
	localparam int W_DEV_LO     = 11;
	localparam int W_REG_LO     = 8;
	// ---------------------------------------------------------------------
	// Wishbone word indices
	// ---------------------------------------------------------------------
	localparam logic [2:0]  WB_DAC_IDX = 3'h6;
	localparam logic [2:0]  WB_ADC_IDX = 3'h7;
	// ---------------------------------------------------------------------
	// Port sequencing states
	// ---------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_CLEAR = 2'b00,
		ST_RUN   = 2'b01
	} port_state_t;
endpackage

// ### rtl/sync_two_ff.sv
// Purpose: Two flip-flop synchroniser for a pin level
// Assumes: Single bit, no reset value needed beyond zero
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
	input  wire logic sys_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic level_i,
	output logic      level_o
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_state_t;
	sync_state_t q, d;
	always_comb begin
		d    = q;
		d.s1 = level_i;
		d.s2 = q.s1;
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign level_o = q.s2;
endmodule
`default_nettype wire

// ### rtl/count_tick.sv
// Purpose: Wrapping event counter used as a clock-rate divider
// Assumes: last_i may change at any time
// Notes:   Wraps at or above last_i so a shrinking limit never locks it up
`timescale 1ns/1ps
`default_nettype none
module count_tick #(
	parameter int W = 3
) (
	input  wire logic         sys_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         clear_i,
	input  wire logic         step_i,
	input  wire logic [W-1:0] last_i,
	output logic      [W-1:0] count_o,
	output logic              wrap_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} cnt_state_t;
	cnt_state_t q, d;
	always_comb begin
		d = q;
		if (clear_i) begin
			d.cnt = '0;
		end else if (step_i) begin
			d.cnt = (q.cnt >= last_i) ? '0 : W'(q.cnt + 1'b1);
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign count_o = q.cnt;
	assign wrap_o  = step_i && !clear_i && (q.cnt >= last_i);
endmodule
`default_nettype wire

// ### rtl/codec_serial_port.sv
// Purpose: Codec serial port, clock dividers and DAC load timing
// Assumes: sys_clk_i acts as the pin master clock; processor port is a slave
// Notes:   Bit clock period is never below 8 system clocks
// Behaviour
// - Mute bit silences decoder output
// - Reference output only while enable bit set
// - Cascade up to eight codecs on one port
// - Words shift MSB first at bit clock
// - Codec is master, starts every transfer
// - Program mode: words with MSB set are control words
// - Data mode: words update DAC, carry ADC
// - Mixed mode: MSB flags control, 15 bits
// - One shared shift register, ADC overwrites it
// - Master clock divide by 1 to 5
// - Bit clock divide by 8, 4, 2, 1
// - Sample rate divide 2048 down to 256
// - Slowest bit clock: two devices at /256
// - Control registers update two clocks after bit clock fall
// - Six 8-bit control, DAC and ADC registers
// - DAC loads sdiv master clocks before frame sync
// - Load advance in steps of eight clocks
// - Control word field layout
// - Nonzero device address: decrement and pass
// - Reset clears registers, first sync later
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port
	import codec_port_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        serial_data_i,
	output logic             serial_data_o,
	output logic             port_bit_clock_o,
	output logic             output_frame_sync_o,
	input  wire logic [15:0] adc_sample_i,
	output logic      [15:0] dac_sample_o,
	output logic             dac_load_o,
	output logic             mute_o,
	output logic             reference_output_enable_o
);
	// ---------------------------------------------------------------------
	// State
	// ---------------------------------------------------------------------
	typedef struct packed {
		port_state_t                  st;
		logic [2:0]                   rst_cnt;
		logic [CR_COUNT-1:0][CR_W-1:0] cr;
		logic [WORD_W-1:0]            sr;
		logic [WORD_W-1:0]            dac_reg;
		logic [WORD_W-1:0]            adc_reg;
		logic [WORD_W-1:0]            dac_out;
		logic [6:0]                   phase;
		logic [3:0]                   bit_idx;
		logic [1:0]                   fall_dly;
		logic                         bclk;
		logic                         fs;
		logic                         sdo;
		logic                         dac_load;
		logic                         mute;
		logic                         buffered_reference_pin;
		logic                         ack;
		logic [31:0]                  rdat;
	} port_reg_t;
	port_reg_t q, d;

	logic              sdi;
	logic [2:0]        mdiv_last;
	logic [3:0]        sdiv;
	logic [10:0]       m_last;
	logic [6:0]        per;
	logic [6:0]        half;
	logic [4:0]        lead;
	logic [11:0]       tgt12;
	logic [10:0]       tgt;
	logic [2:0]        mcnt;
	logic              inner_master_clock_tick;
	logic [10:0]       scnt;
	logic              sample_evt;
	logic              load_evt;
	logic              running;
	logic [WORD_W-1:0] adc_word;
	logic [WORD_W-1:0] w;
	logic [2:0]        dev;
	logic [2:0]        ridx;
	logic [2:0]        wb_idx;
	logic              is_ctrl;

	// ---------------------------------------------------------------------
	// Clock dividers
	// ---------------------------------------------------------------------
	sync_two_ff u_sdi_sync (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.level_i   (serial_data_i),
		.level_o   (sdi)
	);

	always_comb begin
		mdiv_last = q.cr[CR_B][B_MASTER_LO +: 3];
		if (mdiv_last > 3'h4) begin
			mdiv_last = 3'h0;
		end
		case (q.cr[CR_B][B_BITCLK_LO +: 2])
			2'b00:   sdiv = 4'h8;
			2'b01:   sdiv = 4'h4;
			2'b10:   sdiv = 4'h2;
			default: sdiv = 4'h1;
		endcase
		case (q.cr[CR_B][B_SAMPLE_LO +: 2])
			2'b00:   m_last = 11'h7ff;
			2'b01:   m_last = 11'h3ff;
			2'b10:   m_last = 11'h1ff;
			default: m_last = 11'h0ff;
		endcase
		// Input synchroniser needs room inside one bit, so fast rates are capped
		per = 7'(({4'h0, mdiv_last} + 7'h01) * {3'h0, sdiv});
		if (per < MIN_BIT_SYS) begin
			per = MIN_BIT_SYS;
		end
		half = per >> 1;
		lead = q.cr[CR_E][E_LEAD_LO +: 5];
		tgt12 = {1'b0, m_last} - {8'h00, sdiv} - (12'(lead) << LEAD_STEP_LOG2);
		tgt   = tgt12[10:0] & m_last;
	end

	assign running = (q.st == ST_RUN);

	count_tick #(.W(3)) u_master_div (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.clear_i   (1'b0),
		.step_i    (1'b1),
		.last_i    (mdiv_last),
		.count_o   (mcnt),
		.wrap_o    (inner_master_clock_tick)
	);

	count_tick #(.W(11)) u_sample_div (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.clear_i   (!running),
		.step_i    (inner_master_clock_tick),
		.last_i    (m_last),
		.count_o   (scnt),
		.wrap_o    (sample_evt)
	);

	assign load_evt = running && inner_master_clock_tick && (scnt == tgt);
	// Mixed mode gives up the ADC LSB for the flag bit
	assign adc_word = (q.cr[CR_A][A_MIXED_BIT] && q.cr[CR_A][A_MODE_BIT]) ?
		{1'b0, adc_sample_i[WORD_W-1:1]} : adc_sample_i;
	assign w       = {q.sr[WORD_W-2:0], sdi};
	assign dev     = w[W_DEV_LO +: 3];
	assign ridx    = w[W_REG_LO +: 3];
	assign wb_idx  = wb_adr_i[4:2];
	assign is_ctrl = w[W_CTRL_BIT] && !(q.cr[CR_A][A_MODE_BIT] && !q.cr[CR_A][A_MIXED_BIT]);

	// ---------------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------------
	always_comb begin
		d          = q;
		d.dac_load = 1'b0;
		d.ack      = 1'b0;
		// Wishbone slave, one wait state
		if (wb_cyc_i && wb_stb_i && !q.ack) begin
			d.ack  = 1'b1;
			d.rdat = '0;
			if (wb_idx < 3'(CR_COUNT)) begin
				d.rdat[CR_W-1:0] = q.cr[wb_idx];
				if (wb_we_i && wb_sel_i[0]) begin
					d.cr[wb_idx] = wb_dat_i[CR_W-1:0];
				end
			end else if (wb_idx == WB_DAC_IDX) begin
				d.rdat[WORD_W-1:0] = q.dac_reg;
			end else begin
				d.rdat[WORD_W-1:0] = q.adc_reg;
			end
		end
		if (running) begin
			if (sample_evt) begin
				d.sr       = adc_word;
				d.adc_reg  = adc_word;
				d.phase    = '0;
				d.bit_idx  = '0;
				d.fall_dly = '0;
				d.fs       = 1'b1;
				d.bclk     = 1'b1;
				d.sdo      = adc_word[WORD_W-1];
			end else begin
				if (q.phase >= per - 7'h01) begin
					d.phase   = '0;
					d.bit_idx = q.bit_idx + 4'h1;
					d.fs      = 1'b0;
					d.bclk    = 1'b1;
					d.sdo     = q.sr[WORD_W-1];
				end else begin
					d.phase = q.phase + 7'h01;
					d.bclk  = (d.phase < half);
				end
				d.fall_dly = {q.fall_dly[0], d.phase == half};
				// Sampled two clocks after the fall to cover the synchroniser
				if (q.fall_dly[1]) begin
					d.sr = w;
					if (q.bit_idx == 4'hf) begin
						if (is_ctrl) begin
							if (dev != 3'h0) begin
								d.sr[W_DEV_LO +: 3] = dev - 3'h1;
							end else if (ridx < 3'(CR_COUNT)) begin
								if (w[W_READ_BIT]) begin
									d.sr[CR_W-1:0] = q.cr[ridx];
								end else begin
									d.cr[ridx] = w[CR_W-1:0];
								end
							end
						end else if (q.cr[CR_A][A_MODE_BIT]) begin
							d.dac_reg = q.cr[CR_A][A_MIXED_BIT] ?
								{w[WORD_W-2:0], 1'b0} : w;
						end
					end
				end
			end
			if (load_evt) begin
				d.dac_load = 1'b1;
				d.dac_out  = q.dac_reg;
			end
			if (d.cr[CR_A][A_SWRST_BIT]) begin
				d.st      = ST_CLEAR;
				d.rst_cnt = '0;
				d.cr      = '0;
			end
		end else begin
			d.fs   = 1'b0;
			d.bclk = 1'b0;
			d.sdo  = 1'b0;
			d.cr   = '0;
			if (inner_master_clock_tick) begin
				d.rst_cnt = q.rst_cnt + 3'h1;
				if (q.rst_cnt == RESET_INNER_MASTER_CLOCK - 3'h1) begin
					d.st = ST_RUN;
				end
			end
		end
		d.mute   = d.cr[CR_D][D_MUTE_BIT];
		d.buffered_reference_pin = d.cr[CR_C][C_BUFFERED_REFERENCE_PIN_BIT];
		if (d.mute) begin
			d.dac_out = '0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q    <= '0;
			q.st <= ST_CLEAR;
			q.cr <= {CR_COUNT{CR_RESET}};
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o                  = q.rdat;
	assign wb_ack_o                  = q.ack;
	assign serial_data_o             = q.sdo;
	assign port_bit_clock_o          = q.bclk;
	assign output_frame_sync_o       = q.fs;
	assign dac_sample_o              = q.dac_out;
	assign dac_load_o                = q.dac_load;
	assign mute_o                    = q.mute;
	assign reference_output_enable_o = q.buffered_reference_pin;

	// ---------------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_event;
		running && sample_evt;
	endsequence
	sequence s_frame_start;
		output_frame_sync_o && port_bit_clock_o && (q.phase == 7'h00);
	endsequence

	property p_mute;
		mute_o |-> (dac_sample_o == 16'h0000);
	endproperty
	a_mute: assert property (p_mute) else $error("dac not silent while muted");

	property p_buffered_reference_pin;
		reference_output_enable_o == q.cr[CR_C][C_BUFFERED_REFERENCE_PIN_BIT];
	endproperty
	a_buffered_reference_pin: assert property (p_buffered_reference_pin) else $error("reference enable mismatch");

	property p_frame;
		s_event |=> s_frame_start ##1 (output_frame_sync_o && port_bit_clock_o) [*3]
			##1 output_frame_sync_o [*4];
	endproperty
	a_frame: assert property (p_frame) else $error("frame sync not started");

	property p_load_sr;
		s_event |=> (q.sr == $past(adc_word)) && (serial_data_o == q.sr[15]);
	endproperty
	a_load_sr: assert property (p_load_sr) else $error("shift register not loaded");

	property p_fs_at_wrap;
		$rose(output_frame_sync_o) |-> $past(scnt) >= $past(m_last);
	endproperty
	a_fs_at_wrap: assert property (p_fs_at_wrap) else $error("frame sync off sample point");

	property p_clear;
		$rose(q.st == ST_CLEAR) |-> (q.cr == '0) ##[4:12] running;
	endproperty
	a_clear: assert property (p_clear) else $error("reset sequence too long");

	property p_load;
		dac_load_o |-> ($past(scnt) == $past(tgt)) && !output_frame_sync_o;
	endproperty
	a_load: assert property (p_load) else $error("dac load off target");

	property p_pass;
		(running && !sample_evt && q.fall_dly[1] && q.bit_idx == 4'hf && is_ctrl && dev != 3'h0)
			|=> q.sr[W_DEV_LO +: 3] == $past(dev) - 3'h1;
	endproperty
	a_pass: assert property (p_pass) else $error("device address not decremented");

	property p_ack;
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack malformed");
endmodule
`default_nettype wire

// ### tb/proc_port_model.sv
// Purpose: Processor serial port model, slave to the codec
// Assumes: Bench queues words before the frame that carries them
// Notes:   With no fresh word queued the slave resends its last word
`timescale 1ns/1ps
`default_nettype none
module proc_port_model (
	input  wire logic sys_clk_i,
	input  wire logic port_bit_clock_i,
	input  wire logic frame_sync_i,
	input  wire logic codec_data_i,
	output logic      proc_data_o
);
	// ----------------------------------------
	// Shift state
	// ----------------------------------------
	logic [15:0] tx_q[$];
	logic [15:0] rx_q[$];
	logic [15:0] tx_w;
	logic [15:0] rx_w;
	logic        bc_q;
	int          tx_n;
	int          rx_n;
	initial begin
		proc_data_o = 1'b0;
		bc_q = 1'b0;
		tx_w = 16'hffff; // Idle word passes down the cascade; in data mode it loads the DAC
		tx_n = 0;
		rx_n = 0;
	end
	always @(posedge sys_clk_i) begin
		bc_q <= port_bit_clock_i;
		if (port_bit_clock_i && !bc_q) begin
			if (frame_sync_i) begin // Slave: the codec's sync restarts both bit counts
				tx_n = 0;
				rx_n = 0;
			end
			if (tx_n == 0 && tx_q.size() > 0)
				tx_w = tx_q.pop_front(); // Bench keeps words per interval in bounds
			proc_data_o <= tx_w[15 - tx_n]; // MSB first, fields as queued
			tx_n = (tx_n == 15) ? 0 : tx_n + 1;
		end
		if (!port_bit_clock_i && bc_q) begin
			rx_w = {rx_w[14:0], codec_data_i};
			rx_n = rx_n + 1;
			if (rx_n == 16) begin
				rx_q.push_back(rx_w);
				rx_n = 0;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the codec serial port
// Assumes: Bus answers within a few cycles; processor model on the pins
// Notes:   Divider settings checked by edge spacing of sync and bit clock
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [4:0]  wb_adr_i = 5'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [15:0] adc_sample_i = 16'ha5c3;
	logic [31:0] wb_dat_o;
	logic [31:0] r;
	logic [15:0] dac_sample_o;
	logic        wb_ack_o, sdi, sdo, bclk, fs, dac_load_o, mute_o, ref_en, fs_q, bc_q;
	int          n_fail = 0, total_checks = 0, t = 0, rel_t, fs_t = 0, per, hi, bc_t = 0, bp;
	int          ld_t = 0, gap, n_fs = 0, g0;
	always #4 sys_clk_i = ~sys_clk_i;
	codec_serial_port codec_serial_port_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_data_i(sdi), .serial_data_o(sdo),
		.port_bit_clock_o(bclk), .output_frame_sync_o(fs), .adc_sample_i(adc_sample_i),
		.dac_sample_o(dac_sample_o), .dac_load_o(dac_load_o), .mute_o(mute_o),
		.reference_output_enable_o(ref_en));
	proc_port_model proc_port_model_i (.sys_clk_i(sys_clk_i), .port_bit_clock_i(bclk), .frame_sync_i(fs),
		.codec_data_i(sdo), .proc_data_o(sdi));
	// ----------------------------------------
	// Edge timing monitor
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		t <= t + 1;
		fs_q <= fs;
		bc_q <= bclk;
		if (sys_rst_i)
			rel_t <= t;
		if (fs && !fs_q) begin
			per <= t - fs_t;
			fs_t <= t;
			n_fs <= n_fs + 1;
			gap <= t - ld_t;
		end
		if (!fs && fs_q)
			hi <= t - fs_t;
		if (bclk && !bc_q) begin
			bp <= t - bc_t;
			bc_t <= t;
		end
		if (dac_load_o)
			ld_t <= t;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge sys_clk_i);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(r, e);
	endtask
	task automatic wait_fs(input int k);
		int tg;
		tg = n_fs + k;
		for (int i = 0; i < 20000 && n_fs < tg; i++)
			@(posedge sys_clk_i);
		if (n_fs < tg) begin
			n_fail++;
			$display("[FAIL] %0t frame sync missing", $time);
		end
	endtask
	task automatic snd(input logic [15:0] w);
		proc_port_model_i.tx_q.push_back(w);
	endtask
	function automatic logic [31:0] seen(input logic [15:0] w);
		seen = 32'h0;
		foreach (proc_port_model_i.rx_q[i])
			if (proc_port_model_i.rx_q[i] === w)
				seen = 32'h1;
	endfunction
	// ----------------------------------------
	// Watchdog, sized well above the run
	// ----------------------------------------
	initial begin
		repeat (90000) @(posedge sys_clk_i);
		n_fail++;
		finish_test();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		wait_fs(1);
		chk(32'(fs_t - rel_t >= 2048 && fs_t - rel_t <= 2060), 32'h1);
		for (int i = 0; i < 8; i++)
			rd(5'(i * 4), (i == 7) ? 32'ha5c3 : 32'h0);
		wait_fs(1);
		chk(per, 2048);
		chk(hi, 8);
		chk(bp, 8);
		g0 = gap;
		chk(32'(g0 >= 8 && g0 <= 10), 32'h1);
		wr(5'h08, 8'h40);
		chk({31'h0, ref_en}, 32'h1);
		wr(5'h08, 8'h00);
		chk({31'h0, ref_en}, 32'h0);
		wr(5'h10, 8'h1f);
		wait_fs(2);
		chk(gap - g0, 248);
		wr(5'h10, 8'h00);
		// Data mode: DAC in, ADC out
		wr(5'h00, 8'h01);
		proc_port_model_i.rx_q.delete();
		snd(16'h1234);
		wait_fs(3);
		rd(5'h18, 32'h1234);
		chk({16'h0, dac_sample_o}, 32'h1234);
		chk(seen(16'ha5c3), 32'h1);
		rd(5'h1c, 32'ha5c3);
		wr(5'h0c, 8'h80);
		chk({31'h0, mute_o}, 32'h1);
		chk({16'h0, dac_sample_o}, 32'h0);
		wr(5'h0c, 8'h00);
		// Mixed mode: flag bit picks control or sample
		wr(5'h00, 8'h03);
		proc_port_model_i.rx_q.delete();
		snd(16'h8240);
		snd(16'h0abc);
		wait_fs(3);
		rd(5'h18, 32'h1578);
		rd(5'h08, 32'h40);
		chk(seen(16'h52e1), 32'h1);
		wr(5'h08, 8'h00);
		// Program mode: control words, cascade pass-through
		wr(5'h00, 8'h00);
		proc_port_model_i.rx_q.delete();
		snd(16'h8405);
		snd(16'h0412);
		snd(16'h8a33);
		snd(16'hc400);
		snd(16'hb833);
		wait_fs(3);
		rd(5'h10, 32'h05);
		rd(5'h08, 32'h00);
		chk(seen(16'h8233), 32'h1);
		chk(seen(16'hc405), 32'h1);
		chk(seen(16'hb033), 32'h1);
		// Sample rate codes; code 3 at bit /8 leaves room for two words
		for (int s = 0; s < 4; s++) begin
			wr(5'h04, 8'(s));
			wait_fs(2);
			chk(per, 2048 >> s);
		end
		for (int m = 0; m < 8; m++) begin
			wr(5'h04, 8'(m * 16 + 3));
			wait_fs(2);
			chk(per, 256 * (m < 5 ? m + 1 : 1));
			chk(bp, 8 * (m < 5 ? m + 1 : 1));
		end
		// Bit period floor of 8 system clocks
		for (int s = 0; s < 4; s++) begin
			wr(5'h04, 8'(8'h43 + s * 4));
			wait_fs(2);
			chk(bp, (40 >> s) < 8 ? 8 : 40 >> s);
		end
		// Let the sync bit finish before the soft reset cuts the frame
		repeat (16) @(posedge sys_clk_i);
		wr(5'h00, 8'h80);
		repeat (10) @(posedge sys_clk_i);
		rd(5'h04, 32'h0);
		rd(5'h00, 32'h0);
		finish_test();
	end
endmodule
`default_nettype wire
